// *** hdl/amssc_top.sv ***
// Module: converter mode, scan range, status and software reset control
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: Fixed repeat mode interrupts every decimation plus one conversions.
// RULE2: Decimation applies only with repeat one and scan zero.
// RULE3: Repeat bit one selects repeat, zero selects single conversion.
// RULE4: Scan bit one selects channel scan, zero fixed channel.
// RULE5: Scan single does one pass; scan repeat loops the range.
// RULE6: Aborting repeat conversion clears the repeat bit.
// RULE7: Scan starts at start field and steps channels upward.
// RULE8: Range field is channel count minus one.
// RULE9: Software never writes codes 1100 to 1111 to scan fields.
// RULE10: Start plus range above 1011 blocks conversion start.
// RULE11: Priority done flag set when priority conversion completes.
// RULE12: Priority busy flag high during priority conversion.
// RULE13: Normal done flag set when normal conversion completes.
// RULE14: Normal busy flag high during normal conversion.
// RULE15: Status read clears both done flags, not busy flags.
// RULE16: Writing key 10 then 01 performs software reset.
// RULE17: Software reset clears all but the clock setting field.
// RULE18: Initialization after software reset takes 3 us.
// RULE19: Software resets before arming DMA and starting conversions.
// RULE20: Software stops converter before idle or deep stop modes.
// RULE21: Channel code n selects analog input n, 0 to 11.
// RULE22: Decimation counter restarts on sequence start or reset.
module amssc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire amssc_pkg::amssc_bus_t i_bus,
  output logic [31:0] o_rdata,
  // Converter events
  input wire amssc_pkg::amssc_conv_t i_conv,
  // Converter control
  output logic o_conv_go,
  output logic [3:0] o_channel,
  output logic o_scan,
  output logic o_repeat,
  output logic [3:0] o_clk_sel,
  output logic o_conv_irq,
  output logic o_init_busy
);
  import amssc_pkg::*;

  amssc_state_reg_t st_r;
  amssc_state_reg_t st_nxt;

  // ==========================================
  // Helpers
  function automatic logic scan_ok(input logic [3:0] sta, input logic [3:0] area);
    logic [4:0] sum;
    sum = {1'b0, sta} + {1'b0, area};
    scan_ok = (sum <= {1'b0, AMSSC_LAST_CH});
  endfunction

  function automatic logic hit(input amssc_bus_t b, input logic [7:0] ofs);
    hit = (b.addr == ofs);
  endfunction

  // ==========================================
  // Next state
  always_comb
  begin
    logic busy_done;
    logic soft_rst;
    busy_done = 1'b0;
    st_nxt = st_r;
    st_nxt.irq = 1'b0;
    st_nxt.rdata = AMSSC_ZERO32;
    soft_rst = 1'b0;
    // Register writes
    if (i_bus.wr)
    begin
      if (hit(i_bus, AMSSC_OFS_MODE))
      begin
        // RULE3 repeat select
        st_nxt.repeat_en = i_bus.wdata[AMSSC_BIT_REPEAT];
        // RULE4 scan select
        st_nxt.scan = i_bus.wdata[AMSSC_BIT_SCAN];
        st_nxt.itm = i_bus.wdata[AMSSC_ITM_HI:AMSSC_ITM_LO];
      end
      if (hit(i_bus, AMSSC_OFS_SCAN))
      begin
        st_nxt.sta = i_bus.wdata[AMSSC_STA_HI:AMSSC_STA_LO];
        st_nxt.area = i_bus.wdata[AMSSC_AREA_HI:AMSSC_AREA_LO];
      end
      if (hit(i_bus, AMSSC_OFS_CLKS))
      begin
        st_nxt.clks = i_bus.wdata[AMSSC_CLKS_HI:AMSSC_CLKS_LO];
      end
      if (hit(i_bus, AMSSC_OFS_SRST))
      begin
        // RULE16 two step key
        st_nxt.key = i_bus.wdata[AMSSC_KEY_HI:AMSSC_KEY_LO];
        if (st_r.key == AMSSC_KEY_FIRST && i_bus.wdata[AMSSC_KEY_HI:AMSSC_KEY_LO] == AMSSC_KEY_SECOND)
        begin
          soft_rst = 1'b1;
        end
      end
    end
    // Register reads
    if (i_bus.rd)
    begin
      if (hit(i_bus, AMSSC_OFS_MODE))
      begin
        st_nxt.rdata[AMSSC_BIT_SCAN] = st_r.scan;
        st_nxt.rdata[AMSSC_BIT_REPEAT] = st_r.repeat_en;
        st_nxt.rdata[AMSSC_ITM_HI:AMSSC_ITM_LO] = st_r.itm;
      end
      else if (hit(i_bus, AMSSC_OFS_SCAN))
      begin
        st_nxt.rdata[AMSSC_STA_HI:AMSSC_STA_LO] = st_r.sta;
        st_nxt.rdata[AMSSC_AREA_HI:AMSSC_AREA_LO] = st_r.area;
      end
      else if (hit(i_bus, AMSSC_OFS_STAT))
      begin
        st_nxt.rdata[AMSSC_BIT_NBUSY] = st_r.nbusy;
        st_nxt.rdata[AMSSC_BIT_NDONE] = st_r.ndone;
        st_nxt.rdata[AMSSC_BIT_PBUSY] = st_r.pbusy;
        st_nxt.rdata[AMSSC_BIT_PDONE] = st_r.pdone;
        // RULE15 clear on read
        st_nxt.ndone = 1'b0;
        st_nxt.pdone = 1'b0;
      end
      else if (hit(i_bus, AMSSC_OFS_CLKS))
      begin
        st_nxt.rdata[AMSSC_CLKS_HI:AMSSC_CLKS_LO] = st_r.clks;
      end
    end
    // Priority conversion
    if (i_conv.prio_start && st_r.state != AMSSC_INIT)
    begin
      // RULE12 priority busy
      st_nxt.pbusy = 1'b1;
      // RULE11 clear at start
      st_nxt.pdone = 1'b0;
    end
    if (i_conv.prio_done && st_r.pbusy)
    begin
      st_nxt.pbusy = 1'b0;
      // RULE11 priority done
      st_nxt.pdone = 1'b1;
    end
    // Normal conversion sequencer
    case (st_r.state)
      AMSSC_IDLE:
      begin
        // RULE10 refuse bad scan
        if (i_conv.start && (!st_r.scan || scan_ok(st_r.sta, st_r.area)))
        begin
          st_nxt.state = AMSSC_RUN;
          // RULE14 normal busy
          st_nxt.nbusy = 1'b1;
          // RULE13 clear at start
          st_nxt.ndone = 1'b0;
          // RULE22 decimation restart
          st_nxt.dec_cnt = 3'h0;
          // RULE7 start channel
          st_nxt.chan = st_r.scan ? st_r.sta : st_r.chan;
          st_nxt.pass_left = st_r.area;
        end
      end
      AMSSC_RUN:
      begin
        if (i_conv.abort)
        begin
          // RULE6 abort clears repeat
          st_nxt.repeat_en = 1'b0;
          st_nxt.nbusy = 1'b0;
          st_nxt.state = AMSSC_IDLE;
        end
        else if (i_conv.norm_done)
        begin
          if (st_r.scan)
          begin
            if (st_r.pass_left != 4'h0)
            begin
              // RULE7 step upward
              st_nxt.chan = st_r.chan + 4'h1;
              st_nxt.pass_left = st_r.pass_left - 4'h1;
            end
            else
            begin
              // RULE8 range end
              busy_done = 1'b1;
              // RULE5 loop or finish
              st_nxt.chan = st_r.sta;
              st_nxt.pass_left = st_r.area;
            end
          end
          else
          begin
            busy_done = 1'b1;
          end
          if (busy_done)
          begin
            // RULE13 normal done
            st_nxt.ndone = 1'b1;
            if (!st_r.repeat_en)
            begin
              st_nxt.nbusy = 1'b0;
              st_nxt.state = AMSSC_IDLE;
            end
          end
          // RULE2 decimation gating
          if (st_r.repeat_en && !st_r.scan)
          begin
            // RULE1 every itm plus one
            if (st_r.dec_cnt >= st_r.itm)
            begin
              st_nxt.dec_cnt = 3'h0;
              st_nxt.irq = 1'b1;
            end
            else
            begin
              st_nxt.dec_cnt = st_r.dec_cnt + 3'h1;
            end
          end
          else if (busy_done)
          begin
            st_nxt.irq = 1'b1;
          end
        end
      end
      AMSSC_INIT:
      begin
        // RULE18 init wait
        if (st_r.init_cnt != 8'h00)
        begin
          st_nxt.init_cnt = st_r.init_cnt - 8'h01;
        end
        else
        begin
          st_nxt.state = AMSSC_IDLE;
        end
      end
      default:
      begin
        st_nxt.state = AMSSC_IDLE;
      end
    endcase
    // RULE17 soft reset keeps clock field
    if (soft_rst)
    begin
      st_nxt = '0;
      st_nxt.clks = st_r.clks;
      st_nxt.state = AMSSC_INIT;
      st_nxt.init_cnt = AMSSC_INIT_CNT - 8'h01;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  // RULE21 channel code
  assign o_channel = st_r.chan;
  assign o_rdata = st_r.rdata;
  assign o_conv_go = st_r.nbusy;
  assign o_scan = st_r.scan;
  assign o_repeat = st_r.repeat_en;
  assign o_clk_sel = st_r.clks;
  assign o_conv_irq = st_r.irq;
  assign o_init_busy = (st_r.state == AMSSC_INIT);
endmodule
`default_nettype wire

// *** hdl/amssc_pkg.sv ***
// Package: constants and types for the converter mode, scan and status control
package amssc_pkg;
  // ==========================================
  // Register offsets (byte addresses, chosen)
  localparam logic [7:0] AMSSC_OFS_MODE = 8'h00;
  localparam logic [7:0] AMSSC_OFS_SCAN = 8'h04;
  localparam logic [7:0] AMSSC_OFS_STAT = 8'h08;
  localparam logic [7:0] AMSSC_OFS_SRST = 8'h0c;
  localparam logic [7:0] AMSSC_OFS_CLKS = 8'h10;
  // ==========================================
  // Field positions
  localparam int AMSSC_BIT_SCAN = 0;
  localparam int AMSSC_BIT_REPEAT = 1;
  localparam int AMSSC_ITM_LO = 4;
  localparam int AMSSC_ITM_HI = 6;
  localparam int AMSSC_STA_LO = 0;
  localparam int AMSSC_STA_HI = 3;
  localparam int AMSSC_AREA_LO = 4;
  localparam int AMSSC_AREA_HI = 7;
  localparam int AMSSC_BIT_NBUSY = 0;
  localparam int AMSSC_BIT_NDONE = 1;
  localparam int AMSSC_BIT_PBUSY = 2;
  localparam int AMSSC_BIT_PDONE = 3;
  localparam int AMSSC_KEY_LO = 0;
  localparam int AMSSC_KEY_HI = 1;
  localparam int AMSSC_CLKS_LO = 0;
  localparam int AMSSC_CLKS_HI = 3;
  // ==========================================
  // Values
  localparam logic [1:0] AMSSC_KEY_FIRST = 2'h2;
  localparam logic [1:0] AMSSC_KEY_SECOND = 2'h1;
  localparam logic [3:0] AMSSC_LAST_CH = 4'hb;
  localparam logic [2:0] AMSSC_ITM_RST = 3'h0;
  localparam logic [3:0] AMSSC_CH_RST = 4'h0;
  localparam logic [3:0] AMSSC_CLKS_RST = 4'h0;
  localparam logic [31:0] AMSSC_ZERO32 = 32'h0000_0000;
  // ==========================================
  // Timing
  localparam int AMSSC_CLK_MHZ = 25;
  localparam int AMSSC_INIT_NS = 3000;
  localparam int AMSSC_INIT_CYC = (AMSSC_INIT_NS * AMSSC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] AMSSC_INIT_CNT = 8'(AMSSC_INIT_CYC);
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    AMSSC_IDLE,
    AMSSC_RUN,
    AMSSC_INIT
  } amssc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } amssc_bus_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic norm_done;
    logic prio_start;
    logic prio_done;
  } amssc_conv_t;

  typedef struct packed {
    amssc_state_t state;
    logic scan;
    logic repeat_en;
    logic [2:0] itm;
    logic [3:0] sta;
    logic [3:0] area;
    logic [3:0] clks;
    logic [1:0] key;
    logic nbusy;
    logic ndone;
    logic pbusy;
    logic pdone;
    logic [2:0] dec_cnt;
    logic [3:0] chan;
    logic [3:0] pass_left;
    logic [7:0] init_cnt;
    logic irq;
    logic [31:0] rdata;
  } amssc_state_reg_t;
endpackage

// *** tb/amssc_checker.sv ***
// Checker: port assertions of mode, status and reset control
`timescale 1ns/1ps
`default_nettype none
module amssc_checker (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Watched ports
  input wire amssc_pkg::amssc_bus_t i_bus,
  input wire logic [31:0] o_rdata,
  input wire amssc_pkg::amssc_conv_t i_conv,
  input wire logic o_conv_go,
  input wire logic o_scan,
  input wire logic o_repeat,
  input wire logic [3:0] o_clk_sel,
  input wire logic o_conv_irq,
  input wire logic o_init_busy
);
  import amssc_pkg::*;
  logic [7:0] run_r;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ==========
  // Init length count
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      run_r <= 8'h00;
    else
      run_r <= o_init_busy ? run_r + 8'h01 : 8'h00;
  // ==========
  // Steps
  sequence s_stat;
    i_bus.rd && i_bus.addr == AMSSC_OFS_STAT && !i_conv.norm_done && !i_conv.prio_done;
  endsequence
  sequence s_key;
    i_bus.wr && i_bus.addr == AMSSC_OFS_SRST && i_bus.wdata[1:0] == AMSSC_KEY_FIRST ##1
    i_bus.wr && i_bus.addr == AMSSC_OFS_SRST && i_bus.wdata[1:0] == AMSSC_KEY_SECOND;
  endsequence
  // ==========
  // Properties
  property p_clr; s_stat ##1 s_stat |=> !o_rdata[3] && !o_rdata[1]; endproperty
  a_clr: assert property (p_clr) else $error("done flag kept after read");
  property p_pdone; i_conv.prio_start ##1 (i_conv.prio_done && !i_bus.rd) ##1 s_stat |=> o_rdata[3:2] == 2'b10;
  endproperty
  a_pdone: assert property (p_pdone) else $error("priority flags wrong");
  property p_key; s_key |=> o_init_busy && !o_scan && !o_repeat && o_clk_sel == $past(o_clk_sel); endproperty
  a_key: assert property (p_key) else $error("soft reset wrong");
  property p_init; $fell(o_init_busy) |-> run_r == 8'(AMSSC_INIT_CYC); endproperty
  a_init: assert property (p_init) else $error("init length wrong");
  property p_abort; o_repeat && o_conv_go && i_conv.abort && !i_bus.wr |=> !o_repeat && !o_conv_go; endproperty
  a_abort: assert property (p_abort) else $error("abort kept repeat");
  property p_mode; i_bus.wr && i_bus.addr == AMSSC_OFS_MODE && !o_init_busy |=>
    o_scan == $past(i_bus.wdata[0]) && o_repeat == $past(i_bus.wdata[1]); endproperty
  a_mode: assert property (p_mode) else $error("mode bits wrong");
  property p_single; o_conv_go && !o_scan && !o_repeat && i_conv.norm_done && !i_conv.abort |=>
    o_conv_irq && !o_conv_go ##1 !o_conv_irq; endproperty
  a_single: assert property (p_single) else $error("single end wrong");
  property p_start; i_conv.start && !o_conv_go && !o_scan && !o_init_busy |=> o_conv_go; endproperty
  a_start: assert property (p_start) else $error("start not taken");
endmodule
`default_nettype wire

// *** tb/amssc_top_tb_top.sv ***
// Testbench: register, conversion and software reset scenarios
`timescale 1ns/1ps
`default_nettype none
module amssc_top_tb_top;
  import amssc_pkg::*;
  localparam amssc_conv_t GO = 5'h10;
  localparam amssc_conv_t STP = 5'h08;
  localparam amssc_conv_t DN = 5'h04;
  localparam amssc_conv_t PGO = 5'h02;
  localparam amssc_conv_t PDN = 5'h01;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  amssc_bus_t bus = '0;
  amssc_conv_t cv = '0;
  logic [31:0] rdata;
  logic go, scan, rep, irq, busy;
  logic [3:0] ch, clks;
  logic [31:0] exp_q[$], msk_q[$];
  logic rd_d = 1'b0;
  int num_errors = 0;
  int checks = 0;
  int irqs = 0;
  int s, a, n, b;
  logic [8:0] sa[4] = '{9'h048, 9'h174, 9'h10b, 9'h01b};
  always #20 i_clk = ~i_clk;
  amssc_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata), .i_conv(cv), .o_conv_go(go),
    .o_channel(ch), .o_scan(scan), .o_repeat(rep), .o_clk_sel(clks), .o_conv_irq(irq), .o_init_busy(busy));
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic r, input logic [7:0] ad, input logic [31:0] d, input logic [31:0] m = '1);
    bus <= '{addr: ad, wdata: d, wr: !r, rd: r};
    if (r)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge i_clk);
  endtask
  task automatic idle(input int c);
    bus <= '0;
    repeat (c) @(posedge i_clk);
  endtask
  task automatic ev(input amssc_conv_t e);
    cv <= e;
    @(posedge i_clk);
    cv <= '0;
    @(posedge i_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Result watcher
  always @(posedge i_clk)
  begin
    rd_d <= bus.rd;
    if (irq === 1'b1)
      irqs <= irqs + 1;
  end
  always @(negedge i_clk)
    if (rd_d && exp_q.size() > 0)
      chk("rdata", exp_q.pop_front(), rdata & msk_q.pop_front());
  // ==========
  // Scenarios
  initial
  begin
    void'($urandom(60));
    s = $urandom_range(11);
    a = $urandom_range(11 - s);
    n = $urandom;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    op(0, 8'h14, n);
    for (int i = 0; i < 6; i++)
      op(1, 8'(4 * i), 0);
    op(0, AMSSC_OFS_MODE, n);
    op(0, AMSSC_OFS_SCAN, n & 32'hffff_ff00 | a << 4 | s);
    op(0, AMSSC_OFS_CLKS, n);
    op(1, AMSSC_OFS_MODE, n & 32'h73);
    op(1, AMSSC_OFS_SCAN, a << 4 | s);
    op(1, AMSSC_OFS_CLKS, n & 32'hf);
    op(0, AMSSC_OFS_MODE, 32'h70);
    idle(1);
    b = irqs;
    ev(GO);
    op(1, AMSSC_OFS_STAT, 32'h1, 32'hb);
    idle(1);
    ev(DN);
    op(1, AMSSC_OFS_STAT, 32'h2, 32'hb);
    op(1, AMSSC_OFS_STAT, 32'h0, 32'hb);
    idle(1);
    chk("irq", b + 1, irqs);
    for (int k = 0; k < 8; k++)
    begin
      op(0, AMSSC_OFS_MODE, k << 4 | 2);
      idle(1);
      b = irqs;
      ev(GO);
      repeat (16) ev(DN);
      ev(STP);
      chk("irqs", 16 / (k + 1), irqs - b);
      op(1, AMSSC_OFS_MODE, k << 4);
      idle(1);
    end
    for (int r = 0; r < 2; r++)
    begin
      op(0, AMSSC_OFS_MODE, r << 1 | 1);
      idle(1);
      b = irqs;
      ev(GO);
      for (int p = 0; p <= r; p++)
        for (int c = 0; c <= a; c++)
        begin
          chk("chan", s + c, ch);
          ev(DN);
        end
      chk("go", r, go);
      ev(STP);
      chk("pass", r + 1, irqs - b);
    end
    foreach (sa[i])
    begin
      op(0, AMSSC_OFS_SCAN, sa[i][7:0]);
      op(0, AMSSC_OFS_MODE, 1);
      idle(1);
      ev(GO);
      chk("go", sa[i][8], go);
      ev(STP);
    end
    ev(PGO);
    op(1, AMSSC_OFS_STAT, 32'h4, 32'hc);
    idle(0);
    cv <= PGO;
    @(posedge i_clk);
    cv <= PDN;
    @(posedge i_clk);
    cv <= '0;
    op(1, AMSSC_OFS_STAT, 32'h8, 32'hc);
    op(1, AMSSC_OFS_STAT, 32'h0, 32'hc);
    op(0, AMSSC_OFS_CLKS, 5);
    op(0, AMSSC_OFS_MODE, 32'h73);
    op(0, AMSSC_OFS_SRST, 2);
    op(0, AMSSC_OFS_SRST, 1);
    bus <= '0;
    n = 0;
    repeat (200)
    begin
      @(negedge i_clk);
      if (busy !== 1'b1)
        break;
      n++;
    end
    chk("init", AMSSC_INIT_CYC, n);
    if (n == 200)
      stop_test();
    @(posedge i_clk);
    chk("clk", 5, clks);
    op(1, AMSSC_OFS_MODE, 0);
    op(1, AMSSC_OFS_CLKS, 5);
    idle(1);
    ev(GO);
    i_rst <= 1'b1;
    #1;
    chk("go", 0, go);
    @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    op(1, AMSSC_OFS_CLKS, 0);
    idle(2);
    stop_test();
  end
endmodule
bind amssc_top amssc_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_conv(i_conv), .o_conv_go(o_conv_go), .o_scan(o_scan), .o_repeat(o_repeat), .o_clk_sel(o_clk_sel),
  .o_conv_irq(o_conv_irq), .o_init_busy(o_init_busy));
`default_nettype wire
